// ==== logic/dbg_watch_pkg.sv ====
// Purpose: constants shared by the tile debug and watchpoint register block
// Assumes: register numbers are tile configuration register indexes
// Notes: shared field positions and word and byte reset values are kept here
package dbg_watch_pkg;
  // ==========================================================
  // register numbers
  localparam logic [15:0] REG_RESOURCE_COUNTS = 16'h0001;
  localparam logic [15:0] REG_TIMER_CLOCK_COUNTS = 16'h0002;
  localparam logic [15:0] REG_WRITE_RESTRICT = 16'h0004;
  localparam logic [15:0] REG_IRQ_CAUSE = 16'h0015;
  localparam logic [15:0] REG_CAPTURE_VALUE = 16'h0016;
  localparam logic [15:0] REG_STOP_VECTOR = 16'h0018;
  localparam logic [15:0] REG_FIRST_BOUND_BASE = 16'h0050;
  localparam logic [15:0] REG_SECOND_BOUND_BASE = 16'h0060;
  localparam logic [15:0] REG_WATCH_CONTROL_BASE = 16'h0070;
  localparam logic [15:0] REG_RES_MASK_BASE = 16'h0080;
  // ==========================================================
  // field positions
  localparam int WC_ENABLE_BIT = 0;
  localparam int WC_OUTSIDE_BIT = 1;
  localparam int WC_LOAD_BIT = 2;
  localparam int WC_CORE_LSB = 16;
  localparam int CAUSE_INDEX_LSB = 16;
  localparam int CAUSE_CORE_LSB = 8;
  localparam int DESC_HIGH_LSB = 24;
  localparam int DESC_MID_LSB = 16;
  localparam int DESC_LOW_LSB = 8;
  localparam int DESC2_CLK_LSB = 8;
  // ==========================================================
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ==========================================================
  // debug interrupt cause codes
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_HOST = 3'h1;
  localparam logic [2:0] CAUSE_DEBUG_CALL = 3'h2;
  localparam logic [2:0] CAUSE_INSTR_BREAK = 3'h3;
  localparam logic [2:0] CAUSE_DATA_WATCH = 3'h4;
  localparam logic [2:0] CAUSE_RES_WATCH = 3'h5;
endpackage

// ==== logic/watch_compare.sv ====
// Purpose: one data watchpoint comparator
// Assumes: access signals are valid in the cycle of the memory stage
// Notes: purely combinational, one instance per watchpoint
`timescale 1ns/1ps
module watch_compare
  import dbg_watch_pkg::*;
#(
  parameter int NUM_CORES = 8
) (
  // configuration
  input wire logic [31:0] first_bound,
  input wire logic [31:0] second_bound,
  input wire logic [31:0] control,
  // access under test
  input wire logic acc_valid,
  input wire logic acc_store,
  input wire logic [$clog2(NUM_CORES)-1:0] acc_core,
  input wire logic [31:0] acc_addr,
  // result
  output logic hit
);
  // ==========================================================
  // elaboration checks
  // the per-core enable field is one byte wide, so more cores cannot be served
  if (NUM_CORES < 2 || NUM_CORES > 8) begin : g_core_chk
    $error("core count must be 2 to 8");
  end

  // ==========================================================
  // compare
  wire logic in_range = (acc_addr >= first_bound) && (acc_addr <= second_bound);
  wire logic range_ok = control[WC_OUTSIDE_BIT] ? !in_range : in_range;
  wire logic kind_ok = acc_store || control[WC_LOAD_BIT];
  wire logic core_ok = control[WC_CORE_LSB + int'(acc_core)];
  assign hit = acc_valid && control[WC_ENABLE_BIT] && kind_ok && core_ok && range_ok;
endmodule // watch_compare

// ==== logic/tile_debug_watchpoint_regs.sv ====
// Purpose: tile debug registers, data and resource watchpoints, core stop vector
// Assumes: one config access per cycle; answer comes one cycle after the request
// Notes: debug-protected writes need debug mode locally or an unrestricted switch path
`timescale 1ns/1ps
module tile_debug_watchpoint_regs
  import dbg_watch_pkg::*;
#(
  parameter int NUM_CORES = 8,
  parameter int NUM_WATCH = 4,
  parameter logic [7:0] CHANEND_COUNT = 8'h20,
  parameter logic [7:0] LOCK_COUNT = 8'h04,
  parameter logic [7:0] SYNC_COUNT = 8'h07,
  parameter logic [7:0] CLOCK_BLOCK_COUNT = 8'h06,
  parameter logic [7:0] TIMER_COUNT = 8'h0a
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // configuration access
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic cfg_remote,
  input wire logic [15:0] cfg_regnum,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_done,
  output logic cfg_ok,
  output logic [31:0] cfg_rdata,
  // memory stage access
  input wire logic mem_valid,
  input wire logic mem_store,
  input wire logic [2:0] mem_core,
  input wire logic [31:0] mem_addr,
  // resource access
  input wire logic res_valid,
  input wire logic [31:0] res_id,
  // other debug sources
  input wire logic host_dbg_req,
  input wire logic debug_call_instruction,
  input wire logic [2:0] call_core,
  input wire logic [NUM_WATCH-1:0] ibreak_hit,
  input wire logic debug_mode,
  // debug outputs
  output logic dbg_irq,
  output logic [NUM_CORES-1:0] core_stop
);
  // ==========================================================
  // elaboration checks
  if (NUM_CORES != 8) begin : g_core_chk
    $error("core count must be 8");
  end
  if (NUM_WATCH != 4) begin : g_watch_chk
    $error("watchpoint count must be 4");
  end

  // ==========================================================
  // state
  logic [31:0] first_q [NUM_WATCH];
  logic [31:0] second_q [NUM_WATCH];
  logic [31:0] wctl_q [NUM_WATCH];
  logic [31:0] rmask_q [NUM_WATCH];
  logic restrict_q;
  logic [31:0] capture_q;
  logic [7:0] stop_q;
  logic [2:0] cause_q;
  logic [1:0] index_q;
  logic [7:0] cause_core_q;
  logic irq_q;
  logic done_q;
  logic ok_q;
  logic [31:0] rdata_q;

  // ==========================================================
  // decode
  wire logic [15:0] bank = {cfg_regnum[15:2], 2'b00};
  wire logic [1:0] slot = cfg_regnum[1:0];
  wire logic hit_first = (bank == REG_FIRST_BOUND_BASE);
  wire logic hit_second = (bank == REG_SECOND_BOUND_BASE);
  wire logic hit_wctl = (bank == REG_WATCH_CONTROL_BASE);
  wire logic hit_rmask = (bank == REG_RES_MASK_BASE);
  wire logic hit_desc1 = (cfg_regnum == REG_RESOURCE_COUNTS);
  wire logic hit_desc2 = (cfg_regnum == REG_TIMER_CLOCK_COUNTS);
  wire logic hit_restrict = (cfg_regnum == REG_WRITE_RESTRICT);
  wire logic hit_cause = (cfg_regnum == REG_IRQ_CAUSE);
  wire logic hit_capture = (cfg_regnum == REG_CAPTURE_VALUE);
  wire logic hit_stop = (cfg_regnum == REG_STOP_VECTOR);
  wire logic hit_prot = hit_first | hit_second | hit_wctl | hit_rmask | hit_cause
                        | hit_capture | hit_stop;
  wire logic hit_any = hit_prot | hit_desc1 | hit_desc2 | hit_restrict;
  // protected writes: local side only in debug mode, switch side only when unrestricted
  wire logic wr_allowed = cfg_remote ? !restrict_q : debug_mode;
  wire logic wr_prot = cfg_valid && cfg_write && hit_prot && wr_allowed;
  // the restrict bit is itself protected
  wire logic wr_restrict = cfg_valid && cfg_write && hit_restrict && wr_allowed;
  wire logic acc_ok = hit_any && (!cfg_write || ((hit_prot || hit_restrict) && wr_allowed));

  // ==========================================================
  // watchpoint compare, all four in parallel
  logic [NUM_WATCH-1:0] data_hit;
  logic [NUM_WATCH-1:0] res_hit;
  for (genvar i = 0; i < NUM_WATCH; i++) begin : g_watch
    watch_compare #(.NUM_CORES(NUM_CORES)) u_cmp (
      .first_bound(first_q[i]),
      .second_bound(second_q[i]),
      .control(wctl_q[i]),
      .acc_valid(mem_valid),
      .acc_store(mem_store),
      .acc_core(mem_core),
      .acc_addr(mem_addr),
      .hit(data_hit[i])
    );
    // a mask of zero never fires; all mask bits must be present in the id
    assign res_hit[i] = res_valid && (rmask_q[i] != RST_WORD)
                        && ((res_id & rmask_q[i]) == rmask_q[i]);
  end

  // lowest index wins
  function automatic logic [1:0] low_index(input logic [3:0] v);
    logic [1:0] r;
    r = 2'd3;
    if (v[2]) r = 2'd2;
    if (v[1]) r = 2'd1;
    if (v[0]) r = 2'd0;
    return r;
  endfunction

  // ==========================================================
  // event priority: data watch, resource watch, breakpoint, call, host
  wire logic ev_data = |data_hit && !debug_mode;
  wire logic ev_res = |res_hit && !debug_mode;
  wire logic ev_ibrk = |ibreak_hit && !debug_mode;
  wire logic ev_call = debug_call_instruction && !debug_mode;
  wire logic ev_host = host_dbg_req && !debug_mode;
  wire logic ev_any = ev_data | ev_res | ev_ibrk | ev_call | ev_host;
  wire logic [2:0] ev_cause = ev_data ? CAUSE_DATA_WATCH :
                              ev_res ? CAUSE_RES_WATCH :
                              ev_ibrk ? CAUSE_INSTR_BREAK :
                              ev_call ? CAUSE_DEBUG_CALL : CAUSE_HOST;
  wire logic [1:0] ev_index = ev_data ? low_index(data_hit) :
                              ev_res ? low_index(res_hit) :
                              ev_ibrk ? low_index(ibreak_hit) : 2'd0;
  wire logic [7:0] ev_core = ev_data ? {5'd0, mem_core} :
                             (ev_call && !ev_res && !ev_ibrk) ? {5'd0, call_core} : RST_BYTE;

  // ==========================================================
  // read mux
  wire logic [31:0] desc1 = ({24'd0, CHANEND_COUNT} << DESC_HIGH_LSB)
                            | ({24'd0, LOCK_COUNT} << DESC_MID_LSB)
                            | ({24'd0, SYNC_COUNT} << DESC_LOW_LSB);
  wire logic [31:0] desc2 = ({24'd0, CLOCK_BLOCK_COUNT} << DESC2_CLK_LSB)
                            | {24'd0, TIMER_COUNT};
  wire logic [31:0] cause_word = ({30'd0, index_q} << CAUSE_INDEX_LSB)
                                 | ({24'd0, cause_core_q} << CAUSE_CORE_LSB)
                                 | {29'd0, cause_q};
  wire logic [31:0] rd_mux = hit_first ? first_q[slot] :
                             hit_second ? second_q[slot] :
                             hit_wctl ? wctl_q[slot] :
                             hit_rmask ? rmask_q[slot] :
                             hit_desc1 ? desc1 :
                             hit_desc2 ? desc2 :
                             hit_restrict ? {31'd0, restrict_q} :
                             hit_cause ? cause_word :
                             hit_capture ? capture_q :
                             hit_stop ? {24'd0, stop_q} : RST_WORD;
  // reserved control bits are not stored
  wire logic [31:0] wctl_wmask = 32'h00ff_0007;

  // ==========================================================
  // watchpoint configuration registers
  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_WATCH; i++) begin
      if (srst) begin
        first_q[i] <= RST_WORD;
        second_q[i] <= RST_WORD;
        wctl_q[i] <= RST_WORD;
        rmask_q[i] <= RST_WORD;
      end else if (wr_prot && (int'(slot) == i)) begin
        if (hit_first) first_q[i] <= cfg_wdata;
        if (hit_second) second_q[i] <= cfg_wdata;
        if (hit_wctl) wctl_q[i] <= cfg_wdata & wctl_wmask;
        if (hit_rmask) rmask_q[i] <= cfg_wdata;
      end
    end
  end

  // ==========================================================
  // debug state; a hardware event wins over a write in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      restrict_q <= 1'b0;
      capture_q <= RST_WORD;
      stop_q <= RST_BYTE;
      cause_q <= CAUSE_NONE;
      index_q <= 2'd0;
      cause_core_q <= RST_BYTE;
      irq_q <= 1'b0;
    end else begin
      irq_q <= ev_any;
      if (wr_restrict) restrict_q <= cfg_wdata[0];
      if (wr_prot && hit_stop) stop_q <= cfg_wdata[7:0];
      if (ev_data) begin
        capture_q <= mem_addr;
      end else if (ev_res) begin
        capture_q <= res_id;
      end else if (wr_prot && hit_capture) begin
        capture_q <= cfg_wdata;
      end
      if (ev_any) begin
        cause_q <= ev_cause;
        index_q <= ev_index;
        cause_core_q <= ev_core;
      end else if (wr_prot && hit_cause) begin
        cause_q <= cfg_wdata[2:0];
        index_q <= cfg_wdata[CAUSE_INDEX_LSB +: 2];
        cause_core_q <= cfg_wdata[CAUSE_CORE_LSB +: 8];
      end
    end
  end

  // ==========================================================
  // configuration answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (srst) begin
      done_q <= 1'b0;
      ok_q <= 1'b0;
      rdata_q <= RST_WORD;
    end else begin
      done_q <= cfg_valid;
      ok_q <= cfg_valid && acc_ok;
      if (cfg_valid) rdata_q <= (cfg_write || !hit_any) ? RST_WORD : rd_mux;
    end
  end

  assign cfg_done = done_q;
  assign cfg_ok = ok_q;
  assign cfg_rdata = rdata_q;
  assign dbg_irq = irq_q;
  // stop applies only outside debug mode
  assign core_stop = debug_mode ? '0 : stop_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_capture_data_addr: assert property (ev_data |=> capture_q == $past(mem_addr))
    else $error("capture missed data address");
  a_capture_res_id: assert property (!ev_data && ev_res |=> capture_q == $past(res_id))
    else $error("capture missed resource id");
  a_stop_gated: assert property (!debug_mode |-> core_stop == stop_q)
    else $error("stop vector not applied");
  a_restrict_refuse: assert property (
    cfg_valid && cfg_write && cfg_remote && restrict_q && hit_prot |=> cfg_done && !cfg_ok)
    else $error("restricted write accepted");
  a_restrict_hold: assert property (
    cfg_valid && cfg_write && cfg_remote && restrict_q && hit_stop |=> $stable(stop_q))
    else $error("restricted write changed stop vector");
  a_data_event: assert property (ev_data |=> dbg_irq && cause_q == CAUSE_DATA_WATCH)
    else $error("data hit without interrupt");
  a_low_index: assert property (ev_data && data_hit[0] |=> index_q == 2'd0)
    else $error("lowest index not taken");
  a_disabled_quiet: assert property (wctl_q[0][WC_ENABLE_BIT] == 1'b0 |-> !data_hit[0])
    else $error("disabled watchpoint fired");
  a_load_gate: assert property (
    mem_valid && !mem_store && !wctl_q[1][WC_LOAD_BIT] |-> !data_hit[1])
    else $error("load fired without load enable");
  a_core_gate: assert property (
    mem_valid && !wctl_q[2][WC_CORE_LSB + int'(mem_core)] |-> !data_hit[2])
    else $error("watchpoint fired for disabled core");
  a_range_inside: assert property (
    mem_valid && mem_store && wctl_q[3] == 32'h00ff_0001 && mem_addr == first_q[3]
    && first_q[3] <= second_q[3] |-> data_hit[3])
    else $error("inclusive bound missed");
  a_desc_counts: assert property (
    cfg_valid && !cfg_write && hit_desc2 |=> cfg_rdata[7:0] == TIMER_COUNT)
    else $error("timer count wrong");
  // bound writes must land in the addressed slot, not in a neighbour
  a_first_write: assert property (
    wr_prot && hit_first |=> first_q[$past(slot)] == $past(cfg_wdata))
    else $error("first bound write lost");
  a_second_write: assert property (
    wr_prot && hit_second |=> second_q[$past(slot)] == $past(cfg_wdata))
    else $error("second bound write lost");
  a_res_event: assert property (
    !ev_data && ev_res |=> dbg_irq && cause_q == CAUSE_RES_WATCH)
    else $error("resource hit without cause");
  a_debug_quiet: assert property (debug_mode |=> !dbg_irq)
    else $error("interrupt raised in debug mode");
  a_desc1_counts: assert property (
    cfg_valid && !cfg_write && hit_desc1 |=> cfg_rdata[31:24] == CHANEND_COUNT
    && cfg_rdata[7:0] == RST_BYTE)
    else $error("resource counts wrong");
endmodule // tile_debug_watchpoint_regs

// ==== test/cfg_debugger.sv ====
// Purpose: debugger model that reaches tile configuration registers
// Assumes: one request per xfer call, answer strobe set on the taking edge and read at the next falling edge
// Notes: idle adds gap cycles before a request to act as a slow debugger
`timescale 1ns/1ps
module cfg_debugger (
  // clock
  input wire logic clk,
  // request
  output logic cfg_valid,
  output logic cfg_write,
  output logic cfg_remote,
  output logic [15:0] cfg_regnum,
  output logic [31:0] cfg_wdata,
  // answer
  input wire logic cfg_done,
  input wire logic cfg_ok,
  input wire logic [31:0] cfg_rdata
);
  int idle = 0;
  initial begin
    cfg_valid = 1'b0;
    cfg_write = 1'b0;
    cfg_remote = 1'b0;
    cfg_regnum = 16'h0000;
    cfg_wdata = 32'h0000_0000;
  end
  // ==========================================================
  // one transfer, driven on falling edges
  task automatic xfer(input logic wr, input logic rem, input logic [15:0] num,
                      input logic [31:0] wd, output logic ok, output logic [31:0] rd);
    repeat (idle) @(negedge clk);
    @(negedge clk);
    cfg_valid = 1'b1;
    cfg_write = wr;
    cfg_remote = rem;
    cfg_regnum = num;
    cfg_wdata = wd;
    @(negedge clk);
    cfg_valid = 1'b0;
    // released write, regnum and wdata flip so a stale value cannot pass for a held one; remote is kept
    cfg_write = ~wr;
    cfg_regnum = ~num;
    cfg_wdata = ~wd;
    ok = cfg_done ? cfg_ok : 1'bx;
    rd = cfg_rdata;
  endtask
endmodule // cfg_debugger

// ==== test/tile_debug_watchpoint_regs_tb.sv ====
// Purpose: self-checking bench for the tile debug and watchpoint registers
// Assumes: default descriptor parameters, bench drives on falling edges
// Notes: watch addresses kept small so bounds are hit often
`timescale 1ns/1ps
module tile_debug_watchpoint_regs_tb;
  import dbg_watch_pkg::*;
  logic clk, srst, cfg_valid, cfg_write, cfg_remote, cfg_done, cfg_ok, ok;
  logic mem_valid, mem_store, res_valid, host_dbg_req, debug_call_instruction;
  logic debug_mode, dbg_irq;
  logic [15:0] cfg_regnum;
  logic [31:0] cfg_wdata, cfg_rdata, mem_addr, res_id, rd, f, s, d, m;
  logic [2:0] mem_core, call_core;
  logic [3:0] ibreak_hit;
  logic [7:0] core_stop;
  logic [31:0] fb [4];
  logic [31:0] sb [4];
  logic [31:0] ctl [4];
  int error_cnt = 0;
  int samples_checked = 0;
  int idx;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  tile_debug_watchpoint_regs DUT (.clk(clk), .srst(srst), .cfg_valid(cfg_valid),
    .cfg_write(cfg_write), .cfg_remote(cfg_remote), .cfg_regnum(cfg_regnum),
    .cfg_wdata(cfg_wdata), .cfg_done(cfg_done), .cfg_ok(cfg_ok), .cfg_rdata(cfg_rdata),
    .mem_valid(mem_valid), .mem_store(mem_store), .mem_core(mem_core), .mem_addr(mem_addr),
    .res_valid(res_valid), .res_id(res_id), .host_dbg_req(host_dbg_req),
    .debug_call_instruction(debug_call_instruction), .call_core(call_core),
    .ibreak_hit(ibreak_hit), .debug_mode(debug_mode), .dbg_irq(dbg_irq),
    .core_stop(core_stop));
  cfg_debugger host (.clk(clk), .cfg_valid(cfg_valid), .cfg_write(cfg_write),
    .cfg_remote(cfg_remote), .cfg_regnum(cfg_regnum), .cfg_wdata(cfg_wdata),
    .cfg_done(cfg_done), .cfg_ok(cfg_ok), .cfg_rdata(cfg_rdata));
  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic rem, input logic [15:0] num, input logic [31:0] exp,
                        input logic [31:0] msk);
    host.xfer(1'b0, rem, num, 32'h0000_0000, ok, rd);
    check({31'h0, ok}, 32'h0000_0001);
    check(rd & msk, exp);
  endtask
  task automatic wr(input logic [15:0] num, input logic [31:0] wd, input logic rem,
                    input logic exp_ok);
    host.xfer(1'b1, rem, num, wd, ok, rd);
    check({31'h0, ok}, {31'h0, exp_ok});
    check(rd, 32'h0000_0000);
  endtask
  // event inputs were set at this falling edge; the interrupt shows one cycle on
  task automatic ev(input logic exp_irq);
    @(negedge clk);
    check({31'h0, dbg_irq}, {31'h0, exp_irq});
    mem_valid = 1'b0;
    res_valid = 1'b0;
    host_dbg_req = 1'b0;
    debug_call_instruction = 1'b0;
    ibreak_hit = 4'h0;
  endtask
  function automatic logic wp_hit(int i, logic [31:0] a, logic st, logic [2:0] c);
    logic inr;
    inr = (fb[i] <= a) && (a <= sb[i]);
    return ctl[i][0] && ctl[i][16 + c] && (st || ctl[i][2]) && (ctl[i][1] ? !inr : inr);
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
  // ==========================================================
  // tests
  initial begin
    {srst, mem_valid, mem_store, res_valid, host_dbg_req, debug_call_instruction} = '0;
    {mem_core, call_core, ibreak_hit, mem_addr, res_id} = '0;
    srst = 1'b1;
    debug_mode = 1'b1;
    void'($urandom(32'h60a5));
    repeat (20) @(negedge clk);
    srst = 1'b0;
    rd_chk(1'b0, REG_RESOURCE_COUNTS, 32'h2004_0700, '1);
    rd_chk(1'b0, REG_TIMER_CLOCK_COUNTS, 32'h0000_060a, '1);
    for (int i = 0; i < 4; i++) begin
      rd_chk(1'b0, REG_WATCH_CONTROL_BASE + 16'(i), 32'h0000_0000, '1);
    end
    wr(REG_RESOURCE_COUNTS, 32'hffff_ffff, 1'b0, 1'b0);
    rd_chk(1'b0, REG_RESOURCE_COUNTS, 32'h2004_0700, '1);
    host.xfer(1'b0, 1'b0, 16'h0003, 32'h0000_0000, ok, rd);
    check({31'h0, ok}, 32'h0000_0000);
    $display("test reset_and_descriptors done");
    repeat (4) begin
      d = $urandom;
      debug_mode = 1'b1;
      wr(REG_STOP_VECTOR, d, 1'b0, 1'b1);
      rd_chk(1'b0, REG_STOP_VECTOR, {24'h0, d[7:0]}, '1);
      check({24'h0, core_stop}, 32'h0000_0000);
      debug_mode = 1'b0;
      @(negedge clk);
      check({24'h0, core_stop}, {24'h0, d[7:0]});
      wr(REG_STOP_VECTOR, ~d, 1'b0, 1'b0);
    end
    $display("test stop_vector done");
    debug_mode = 1'b1;
    wr(REG_WRITE_RESTRICT, 32'h0000_0001, 1'b0, 1'b1);
    wr(REG_FIRST_BOUND_BASE, 32'h1234_5678, 1'b1, 1'b0);
    rd_chk(1'b1, REG_FIRST_BOUND_BASE, 32'h0000_0000, '1);
    wr(REG_STOP_VECTOR, ~d, 1'b1, 1'b0);
    rd_chk(1'b1, REG_STOP_VECTOR, {24'h0, d[7:0]}, '1);
    wr(REG_WRITE_RESTRICT, 32'h0000_0000, 1'b0, 1'b1);
    wr(REG_FIRST_BOUND_BASE, 32'h1234_5678, 1'b1, 1'b1);
    rd_chk(1'b1, REG_FIRST_BOUND_BASE, 32'h1234_5678, '1);
    $display("test restrict done");
    for (int r = 0; r < 6; r++) begin
      debug_mode = 1'b1;
      host.idle = $urandom % 3;
      for (int i = 0; i < 4; i++) begin
        f = $urandom % 64;
        s = $urandom % 64;
        fb[i] = (f < s) ? f : s;
        sb[i] = (f < s) ? s : f;
        ctl[i] = $urandom & 32'h00ff_0007;
        wr(REG_FIRST_BOUND_BASE + 16'(i), fb[i], 1'b0, 1'b1);
        wr(REG_SECOND_BOUND_BASE + 16'(i), sb[i], 1'b0, 1'b1);
        wr(REG_WATCH_CONTROL_BASE + 16'(i), ctl[i], 1'b0, 1'b1);
        rd_chk(1'b0, REG_SECOND_BOUND_BASE + 16'(i), sb[i], '1);
        rd_chk(1'b0, REG_WATCH_CONTROL_BASE + 16'(i), ctl[i], '1);
      end
      debug_mode = 1'b0;
      repeat (12) begin
        @(negedge clk);
        // probe one below, on and one above a bound, where range slips show
        d = (($urandom % 2) ? fb[$urandom % 4] : sb[$urandom % 4]) + ($urandom % 3) - 1;
        mem_valid = 1'b1;
        mem_store = 1'($urandom);
        mem_core = 3'($urandom);
        mem_addr = d;
        idx = -1;
        for (int i = 3; i >= 0; i--) begin
          if (wp_hit(i, d, mem_store, mem_core)) idx = i;
        end
        ev(idx >= 0);
        if (idx >= 0) begin
          rd_chk(1'b0, REG_IRQ_CAUSE, {14'h0, 2'(idx), 5'h0, mem_core, 5'h0, CAUSE_DATA_WATCH},
                 '1);
          rd_chk(1'b0, REG_CAPTURE_VALUE, d, '1);
        end
      end
    end
    // corner: watch 3 alone, probes either side of both bounds in both range modes
    debug_mode = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(REG_WATCH_CONTROL_BASE + 16'(i), 32'h0000_0000, 1'b0, 1'b1);
    end
    wr(REG_FIRST_BOUND_BASE + 16'h0003, 32'h0000_0010, 1'b0, 1'b1);
    wr(REG_SECOND_BOUND_BASE + 16'h0003, 32'h0000_0020, 1'b0, 1'b1);
    wr(REG_WATCH_CONTROL_BASE + 16'h0003, 32'h00ff_0001, 1'b0, 1'b1);
    debug_mode = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (k == 4) begin
        debug_mode = 1'b1;
        wr(REG_WATCH_CONTROL_BASE + 16'h0003, 32'h00ff_0003, 1'b0, 1'b1);
        debug_mode = 1'b0;
      end
      @(negedge clk);
      mem_valid = 1'b1;
      mem_store = 1'b1;
      mem_core = 3'($urandom);
      mem_addr = (k % 4 < 2) ? 32'h0000_000f + 32'(k % 4) : 32'h0000_001e + 32'(k % 4);
      ev(((k % 4 == 1) || (k % 4 == 2)) != (k >= 4));
      if (k == 1) begin
        rd_chk(1'b0, REG_IRQ_CAUSE, {14'h0, 2'd3, 5'h0, mem_core, 5'h0, CAUSE_DATA_WATCH},
               '1);
        rd_chk(1'b0, REG_CAPTURE_VALUE, 32'h0000_0010, '1);
      end
    end
    $display("test data_watch done");
    for (int j = 0; j < 4; j++) begin
      m = $urandom | 32'h0000_0001;
      debug_mode = 1'b1;
      for (int k = 0; k < 4; k++) begin
        wr(REG_RES_MASK_BASE + 16'(k), (k == j) ? m : 32'h0000_0000, 1'b0, 1'b1);
      end
      debug_mode = 1'b0;
      res_valid = 1'b1;
      res_id = ~m;
      ev(1'b0);
      @(negedge clk);
      res_valid = 1'b1;
      res_id = $urandom | m;
      d = res_id;
      ev(1'b1);
      rd_chk(1'b0, REG_IRQ_CAUSE, {14'h0, 2'(j), 13'h0, CAUSE_RES_WATCH}, '1);
      rd_chk(1'b0, REG_CAPTURE_VALUE, d, '1);
    end
    host_dbg_req = 1'b1;
    ev(1'b1);
    rd_chk(1'b0, REG_IRQ_CAUSE, {29'h0, CAUSE_HOST}, 32'h0000_ffff);
    call_core = 3'($urandom);
    debug_call_instruction = 1'b1;
    ev(1'b1);
    rd_chk(1'b0, REG_IRQ_CAUSE, {21'h0, call_core, 5'h0, CAUSE_DEBUG_CALL},
           32'h0000_ffff);
    ibreak_hit = 4'b1100;
    ev(1'b1);
    rd_chk(1'b0, REG_IRQ_CAUSE, {14'h0, 2'd2, 13'h0, CAUSE_INSTR_BREAK}, '1);
    debug_mode = 1'b1;
    host_dbg_req = 1'b1;
    ev(1'b0);
    $display("test resource_and_causes done");
    report_and_stop();
  end
endmodule // tile_debug_watchpoint_regs_tb
